// ---- sfs_buf2.v ----
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module sfs_buf2 (
  input  wire       MCLK,
  input  wire       NRST,
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_r [0:1];
  reg       wp_r;
  reg       rp_r;
  reg [1:0] cnt_r;
  wire      push;
  wire      pop;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge MCLK) begin
    if (!NRST) begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      if (push & ~pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// ---- sfs_defines.vh ----
// Constants for the serial flash interface front end
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH
`define SFS_OP_WREN     8'h06
`define SFS_OP_WRDI     8'h04
`define SFS_OP_RDSR     8'h05
`define SFS_OP_WRSR     8'h01
`define SFS_OP_READ     8'h03
`define SFS_OP_FREAD    8'h0b
`define SFS_OP_DREAD    8'h3b
`define SFS_OP_PP       8'h02
`define SFS_OP_SE       8'h20
`define SFS_OP_BE       8'hd8
`define SFS_OP_CE       8'hc7
`define SFS_OP_PD       8'hb9
`define SFS_OP_RPD      8'hab
`define SFS_SR_BUSY     0
`define SFS_SR_WEL      1
`define SFS_SR_BP0      2
`define SFS_SR_BP1      3
`define SFS_SR_BP2      4
`define SFS_SR_TB       5
`define SFS_SR_LOCK     7
`define SFS_SR_WMASK    8'hbc
`define SFS_BITS_OP     4'h8
`define SFS_BITS_ADDR   6'h20
`define SFS_BITS_FADDR  6'h28
`define SFS_PUW_US      10
`define SFS_BUSY_US     10
`define SFS_CLK_MHZ     100
`endif

// ---- sfs_front.v ----
// Serial flash interface front end: command decode, status, pause and output drive
// What this block does
// - Chip select high deselects and floats the serial output.
// - No instruction accepted after reset until chip select falls.
// - Only clock modes 0 and 3; idle clock level is irrelevant here.
// - Input bits sampled at each rising serial clock edge.
// - Output bits launched at each falling serial clock edge.
// - Dual fast read drives the io pin as a second output.
// - All other instructions keep io pin as input.
// - Pause starts on hold fall if clock low, else next clock fall.
// - Pause ends on hold rise if clock low, else next clock fall.
// - Pause floats output, ignores clock and io, keeps state.
// - Reset disables all operations and instructions.
// - Write-type instructions rejected until power-up delay elapses.
// - Program, erase, status write need the write enable latch set.
// - Write enable latch is read-only status bit one.
// - Latch cleared at reset and after disable, program, erase, accepted status write.
// - Busy is read-only status bit zero during program, erase, status write.
// - While busy only read status is obeyed.
// - Busy clears when the operation completes.
// - In power-down only release power-down is obeyed.
// - Write-protect input is active low and gates status writes with lock.
// - Lock and range bits are loaded by status write.
// - Lock set and protect low refuses status writes.
// - Instruction starts at chip select fall, first byte MSB first.
// - Protect-from-bottom bit selects range origin.
`timescale 1ns/1ps
`include "sfs_defines.vh"
module sfs_front #(
  parameter PUW_CYCLES  = `SFS_PUW_US * `SFS_CLK_MHZ,
  parameter BUSY_CYCLES = `SFS_BUSY_US * `SFS_CLK_MHZ
) (
  input  wire       MCLK,
  input  wire       NRST,
  input  wire       CS_N,
  input  wire       SCLK,
  input  wire       HOLD_N,
  input  wire       WP_N,
  input  wire       SIO_I,
  output wire       SIO_O,
  output wire       SIO_OE,
  output wire       SO_O,
  output wire       SO_OE,
  input  wire [7:0] RD_DATA,
  input  wire       RD_VALID,
  output wire       RD_READY,
  output reg        RD_REQ,
  output reg [23:0] ADDR,
  output reg [7:0]  OPCODE,
  output reg        OP_START,
  output wire [7:0] STATUS,
  output wire       PROTECT_FROM_BOTTOM,
  output wire [2:0] PROTECT_RANGE
);
  localparam ST_OP   = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_OUT  = 3'h3;
  localparam ST_IDLE = 3'h4;

  reg [1:0]  cs_s_r, ck_s_r, hd_s_r, wp_s_r, io_s_r;
  reg        ck_d_r, hd_d_r, cs_d_r;
  reg        armed_r;
  reg        pause_r;
  reg        pend_r;
  reg [2:0]  st_r;
  reg [5:0]  bits_r;
  reg [7:0]  sh_r;
  reg [7:0]  out_r;
  reg [3:0]  outn_r;
  reg        dual_r;
  reg        so_r, sio_r;
  reg        wel_r, busy_r, pd_r;
  reg [7:0]  prot_r;
  reg [31:0] puw_r;
  reg [31:0] busy_cnt_r;
  reg        rd_mode_r;
  wire       cs_n, ck, hd_n, wp_n, io;
  wire       ck_rise, ck_fall, cs_fall;
  wire       active;
  wire       puw_done;
  wire [7:0] sr;
  wire [7:0] buf_data;
  wire       buf_valid;
  reg        buf_pop;
  wire       buf_rst_n;

  assign cs_n = cs_s_r[1];
  assign ck   = ck_s_r[1];
  assign hd_n = hd_s_r[1];
  assign wp_n = wp_s_r[1];
  assign io   = io_s_r[1];
  assign ck_rise = ck & ~ck_d_r;
  assign ck_fall = ~ck & ck_d_r;
  assign cs_fall = ~cs_n & cs_d_r;
  assign active  = ~cs_n & ~pause_r & armed_r;
  assign puw_done = (puw_r == 32'h0);
  assign sr = {prot_r[`SFS_SR_LOCK], 1'b0, prot_r[`SFS_SR_TB], prot_r[`SFS_SR_BP2],
               prot_r[`SFS_SR_BP1], prot_r[`SFS_SR_BP0], wel_r, busy_r};
  assign STATUS = sr;
  assign PROTECT_FROM_BOTTOM = prot_r[`SFS_SR_TB];
  assign PROTECT_RANGE = {prot_r[`SFS_SR_BP2], prot_r[`SFS_SR_BP1], prot_r[`SFS_SR_BP0]};
  // Outputs float when deselected or paused
  assign SO_OE  = ~cs_n & ~pause_r & (st_r == ST_OUT);
  assign SO_O   = so_r;
  assign SIO_OE = SO_OE & dual_r;
  assign SIO_O  = sio_r;
  // Flush stale read bytes once the request drops at deselect
  assign buf_rst_n = NRST & RD_REQ;

  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = (op == `SFS_OP_WREN) | (op == `SFS_OP_PP) | (op == `SFS_OP_SE) |
                    (op == `SFS_OP_BE) | (op == `SFS_OP_CE) | (op == `SFS_OP_WRSR);
    end
  endfunction

  sfs_buf2 u_buf (
    .MCLK      (MCLK),
    .NRST      (buf_rst_n),
    .in_valid  (RD_VALID),
    .in_ready  (RD_READY),
    .in_data   (RD_DATA),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  always @(posedge MCLK) begin
    if (!NRST) begin
      // Select reads low through reset, so a select held low is no fresh fall
      cs_s_r <= 2'h0;
      ck_s_r <= 2'h0;
      hd_s_r <= 2'h3;
      wp_s_r <= 2'h3;
      io_s_r <= 2'h0;
      ck_d_r <= 1'b0;
      hd_d_r <= 1'b1;
      cs_d_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[0], CS_N};
      ck_s_r <= {ck_s_r[0], SCLK};
      hd_s_r <= {hd_s_r[0], HOLD_N};
      wp_s_r <= {wp_s_r[0], WP_N};
      io_s_r <= {io_s_r[0], SIO_I};
      ck_d_r <= ck;
      hd_d_r <= hd_n;
      cs_d_r <= cs_n;
    end
  end

  // Pause entry and exit take effect with clock low, else at the next clock fall
  always @(posedge MCLK) begin
    if (!NRST) begin
      pause_r <= 1'b0;
      pend_r  <= 1'b0;
    end else if (cs_n) begin
      pause_r <= 1'b0;
      pend_r  <= 1'b0;
    end else if (hd_n != hd_d_r) begin
      if (!ck) begin
        pause_r <= ~hd_n;
        pend_r  <= 1'b0;
      end else
        pend_r  <= 1'b1;
    end else if (pend_r & ck_fall) begin
      pause_r <= ~hd_n;
      pend_r  <= 1'b0;
    end
  end

  always @(posedge MCLK) begin
    if (!NRST) begin
      puw_r      <= PUW_CYCLES;
      busy_cnt_r <= 32'h0;
      busy_r     <= 1'b0;
    end else begin
      if (!puw_done)
        puw_r <= puw_r - 32'h1;
      // The start pulse comes only for accepted writes; the latch is already cleared then
      if (OP_START & (OPCODE == `SFS_OP_PP | OPCODE == `SFS_OP_SE | OPCODE == `SFS_OP_BE |
                      OPCODE == `SFS_OP_CE | OPCODE == `SFS_OP_WRSR)) begin
        busy_r     <= 1'b1;
        busy_cnt_r <= BUSY_CYCLES;
      end else if (busy_r) begin
        if (busy_cnt_r == 32'h0)
          busy_r <= 1'b0;
        else
          busy_cnt_r <= busy_cnt_r - 32'h1;
      end
    end
  end

  always @(posedge MCLK) begin
    if (!NRST) begin
      armed_r   <= 1'b0;
      st_r      <= ST_IDLE;
      bits_r    <= 6'h0;
      sh_r      <= 8'h00;
      out_r     <= 8'h00;
      outn_r    <= 4'h0;
      dual_r    <= 1'b0;
      so_r      <= 1'b0;
      sio_r     <= 1'b0;
      wel_r     <= 1'b0;
      pd_r      <= 1'b0;
      prot_r    <= 8'h00;
      OPCODE    <= 8'h00;
      OP_START  <= 1'b0;
      ADDR      <= 24'h0;
      RD_REQ    <= 1'b0;
      rd_mode_r <= 1'b0;
      buf_pop   <= 1'b0;
    end else begin
      OP_START <= 1'b0;
      buf_pop  <= 1'b0;
      if (cs_fall) begin
        armed_r <= 1'b1;
        st_r    <= ST_OP;
        bits_r  <= 6'h0;
        dual_r  <= 1'b0;
        RD_REQ  <= 1'b0;
      end else if (cs_n) begin
        st_r   <= ST_IDLE;
        RD_REQ <= 1'b0;
        if (st_r == ST_DATA && OPCODE == `SFS_OP_WRSR && bits_r == {2'h0, `SFS_BITS_OP}) begin
          if (!(prot_r[`SFS_SR_LOCK] & ~wp_n)) begin
            prot_r   <= sh_r & `SFS_SR_WMASK;
            wel_r    <= 1'b0;
            OP_START <= 1'b1;
          end
          st_r <= ST_IDLE;
        end
      end else if (active & ck_rise) begin
        sh_r   <= {sh_r[6:0], io};
        bits_r <= bits_r + 6'h1;
        if (st_r == ST_OP && bits_r == `SFS_BITS_OP - 4'h1) begin
          OPCODE <= {sh_r[6:0], io};
          bits_r <= 6'h0;
          st_r   <= ST_IDLE;
          if (pd_r) begin
            if ({sh_r[6:0], io} == `SFS_OP_RPD)
              pd_r <= 1'b0;
          end else if (busy_r) begin
            if ({sh_r[6:0], io} == `SFS_OP_RDSR)
              st_r <= ST_OUT;
          end else if (is_write_op({sh_r[6:0], io}) & ~puw_done) begin
            st_r <= ST_IDLE;
          end else begin
            case ({sh_r[6:0], io})
              `SFS_OP_WREN: wel_r <= 1'b1;
              `SFS_OP_WRDI: wel_r <= 1'b0;
              `SFS_OP_PD:   pd_r  <= 1'b1;
              `SFS_OP_RDSR: st_r  <= ST_OUT;
              `SFS_OP_WRSR: st_r  <= wel_r ? ST_DATA : ST_IDLE;
              `SFS_OP_PP, `SFS_OP_SE, `SFS_OP_BE: begin
                if (wel_r) begin
                  st_r  <= ST_ADDR;
                  wel_r <= 1'b0;
                end
              end
              `SFS_OP_CE: begin
                if (wel_r) begin
                  wel_r    <= 1'b0;
                  OP_START <= 1'b1;
                end
              end
              `SFS_OP_READ, `SFS_OP_FREAD, `SFS_OP_DREAD: st_r <= ST_ADDR;
              default: st_r <= ST_IDLE;
            endcase
          end
          outn_r <= 4'h0;
        end else if (st_r == ST_ADDR) begin
          // The dummy byte of the fast reads must not push the address out
          if (bits_r < `SFS_BITS_ADDR - {2'h0, `SFS_BITS_OP})
            ADDR <= {ADDR[22:0], io};
          if (bits_r == ((OPCODE == `SFS_OP_READ || OPCODE == `SFS_OP_PP || OPCODE == `SFS_OP_SE ||
                          OPCODE == `SFS_OP_BE) ? `SFS_BITS_ADDR : `SFS_BITS_FADDR) - 6'h9) begin
            bits_r <= 6'h0;
            if (OPCODE == `SFS_OP_SE || OPCODE == `SFS_OP_BE || OPCODE == `SFS_OP_PP) begin
              OP_START <= 1'b1;
              st_r     <= ST_IDLE;
            end else begin
              st_r   <= ST_OUT;
              RD_REQ <= 1'b1;
              dual_r <= (OPCODE == `SFS_OP_DREAD);
            end
          end
        end
      end else if (active & ck_fall & st_r == ST_OUT) begin
        if (outn_r == 4'h0) begin
          if (OPCODE == `SFS_OP_RDSR) begin
            out_r  <= {sr[6:0], 1'b0};
            so_r   <= sr[7];
            outn_r <= 4'h7;
          end else if (buf_valid) begin
            buf_pop <= 1'b1;
            if (dual_r) begin
              sio_r  <= buf_data[7];
              so_r   <= buf_data[6];
              out_r  <= {buf_data[5:0], 2'h0};
              outn_r <= 4'h3;
            end else begin
              so_r   <= buf_data[7];
              out_r  <= {buf_data[6:0], 1'b0};
              outn_r <= 4'h7;
            end
          end
        end else begin
          outn_r <= outn_r - 4'h1;
          if (dual_r) begin
            sio_r <= out_r[7];
            so_r  <= out_r[6];
            out_r <= {out_r[5:0], 2'h0};
          end else begin
            so_r  <= out_r[7];
            out_r <= {out_r[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

// ---- sfs_front_props.sv ----
// Port assertions for the serial flash front end
`timescale 1ns/1ps
module sfs_front_props #(
  parameter BUSY_CYCLES = 1000
) (
  input wire       MCLK,
  input wire       NRST,
  input wire       CS_N,
  input wire       SCLK,
  input wire       HOLD_N,
  input wire       WP_N,
  input wire       SIO_OE,
  input wire       SO_OE,
  input wire       RD_REQ,
  input wire [7:0] OPCODE,
  input wire       OP_START,
  input wire [7:0] STATUS,
  input wire       PROTECT_FROM_BOTTOM,
  input wire [2:0] PROTECT_RANGE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Busy length counter; pins pass a synchroniser, so a small slack is allowed
  int bcnt_r;
  always @(posedge MCLK) begin
    if (!NRST || !STATUS[0]) bcnt_r <= 0;
    else bcnt_r <= bcnt_r + 1;
  end
  AST_DESEL: assert property (CS_N [*6] |-> !SO_OE && !SIO_OE && !RD_REQ)
    else $error("driving while deselected");
  AST_DUAL: assert property (SIO_OE |-> OPCODE == 8'h3b)
    else $error("io pin driven outside dual read");
  AST_PAUSE: assert property ((!HOLD_N && !SCLK) [*6] |-> !SO_OE)
    else $error("output driven while paused");
  AST_BUSY_LEN: assert property ($fell(STATUS[0]) |-> bcnt_r >= BUSY_CYCLES - 2 && bcnt_r <= BUSY_CYCLES + 2)
    else $error("busy length wrong");
  AST_WEL_DROP: assert property ($rose(STATUS[0]) |-> ##[0:2] !STATUS[1])
    else $error("latch kept after write op");
  AST_BUSY_DEAF: assert property ($rose(STATUS[1]) |-> !$past(STATUS[0]))
    else $error("latch set while busy");
  AST_START: assert property (OP_START |-> ##[0:2] STATUS[0])
    else $error("start without busy");
  AST_LOCK: assert property ((STATUS[7] && !WP_N) [*4] |=> $stable(STATUS[7:2]))
    else $error("locked status changed");
  AST_PROT: assert property (PROTECT_RANGE == STATUS[4:2] && PROTECT_FROM_BOTTOM == STATUS[5])
    else $error("protect outputs differ");
  CVR_DUAL: cover property (SIO_OE);
  CVR_BUSY: cover property ($rose(STATUS[0]));
  CVR_PAUSE: cover property (!HOLD_N && !CS_N);
endmodule
bind sfs_front sfs_front_props #(.BUSY_CYCLES(BUSY_CYCLES)) u_props (
  .MCLK(MCLK), .NRST(NRST), .CS_N(CS_N), .SCLK(SCLK), .HOLD_N(HOLD_N), .WP_N(WP_N),
  .SIO_OE(SIO_OE), .SO_OE(SO_OE), .RD_REQ(RD_REQ), .OPCODE(OPCODE), .OP_START(OP_START),
  .STATUS(STATUS), .PROTECT_FROM_BOTTOM(PROTECT_FROM_BOTTOM), .PROTECT_RANGE(PROTECT_RANGE)
);

// ---- sfs_host.sv ----
// Serial bus master model for the flash front end
`timescale 1ns/1ps
module sfs_host (
  output logic cs_n,
  output logic sclk,
  output logic hold_n,
  output logic sio_d,
  input  wire  so_w,
  input  wire  sio_w
);
  logic m3 = 1'b0;
  logic hp = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hold_n = 1'b1;
    sio_d = 1'b0;
  end
  // Park at the mode level, then a select edge before any byte
  task automatic sel;
    #31;
    sclk = m3;
    #80;
    cs_n = 1'b0;
    #80;
  endtask
  task automatic desel;
    sclk = m3;
    #80;
    cs_n = 1'b1;
    #160;
  endtask
  // Pause with the clock low; select stays low and the pulses must be ignored
  task automatic pause;
    sclk = 1'b0;
    #80;
    hold_n = 1'b0;
    #80;
    repeat (2) begin
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
      #80;
    end
    hold_n = 1'b1;
    #80;
  endtask
  // Data changes in the low half and is taken at the rise
  task automatic bitx(input logic t, output logic a, output logic b);
    sclk = 1'b0;
    sio_d = t;
    #80;
    sclk = 1'b1;
    a = so_w;
    b = sio_w;
    #80;
  endtask
  // When receiving, the io line toggles so a stale level can never pass
  task automatic xb(input logic [7:0] t, input bit rx, input bit dual, output logic [7:0] r);
    logic a;
    logic b;
    for (int i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
      if (hp && i == 3) pause();
      bitx(rx ? ~sio_d : t[i], a, b);
      r[i] = dual ? b : a;
      if (dual) r[i-1] = a;
    end
  endtask
endmodule

// ---- sfs_tb.sv ----
// Bench for the serial flash front end
`timescale 1ns/1ps
`include "sfs_defines.vh"
module testbench;
  logic       MCLK = 1'b0;
  logic       NRST = 1'b0;
  logic       WP_N = 1'b1;
  logic       so_q = 1'b0;
  logic [7:0] r;
  int         k = 0;
  int         miscompares = 0;
  int         tests_run = 0;
  logic [7:0] mem [4] = '{8'ha5, 8'h3c, 8'h96, 8'h0f};
  logic [7:0] ops [4] = '{`SFS_OP_PP, `SFS_OP_SE, `SFS_OP_BE, `SFS_OP_CE};
  wire        CS_N, SCLK, HOLD_N, sio_d, SIO_O, SIO_OE, SO_O, SO_OE, RD_READY, RD_REQ, OP_START, PFB;
  wire [23:0] ADDR;
  wire [7:0]  OPCODE;
  wire [7:0]  STATUS;
  wire [2:0]  PRANGE;
  // Array side offers four bytes so the two-entry buffer fills and refuses
  wire        rd_valid = RD_REQ && k < 4;
  wire [7:0]  rd_data = mem[k[1:0]];
  // A floating output shows the inverse of its last driven level
  wire        so_w = SO_OE ? SO_O : ~so_q;
  wire        sio_w = SIO_OE ? SIO_O : sio_d;
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (SO_OE) so_q <= SO_O;
    k <= !RD_REQ ? 0 : k + (rd_valid && RD_READY);
  end
  sfs_front #(.PUW_CYCLES(300), .BUSY_CYCLES(1000)) DUT (
    .MCLK(MCLK), .NRST(NRST), .CS_N(CS_N), .SCLK(SCLK), .HOLD_N(HOLD_N), .WP_N(WP_N),
    .SIO_I(sio_w), .SIO_O(SIO_O), .SIO_OE(SIO_OE), .SO_O(SO_O), .SO_OE(SO_OE),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(RD_READY), .RD_REQ(RD_REQ), .ADDR(ADDR),
    .OPCODE(OPCODE), .OP_START(OP_START), .STATUS(STATUS), .PROTECT_FROM_BOTTOM(PFB),
    .PROTECT_RANGE(PRANGE));
  sfs_host host (.cs_n(CS_N), .sclk(SCLK), .hold_n(HOLD_N), .sio_d(sio_d), .so_w(so_w), .sio_w(sio_w));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic go(input logic [7:0] op, input logic [31:0] a, input int n);
    // Host pin changes then land 1 ns after a clock edge, like the other inputs
    @(posedge MCLK);
    host.sel();
    host.xb(op, 0, 0, r);
    for (int i = 0; i < n; i++) begin
      host.xb(a[31-8*i -: 8], 0, 0, r);
    end
  endtask
  task automatic one(input logic [7:0] op);
    go(op, 0, 0);
    host.desel();
  endtask
  task automatic rdsr(input logic [7:0] exp);
    go(`SFS_OP_RDSR, 0, 0);
    host.xb(0, 1, 0, r);
    host.desel();
    chk(r, exp);
  endtask
  task automatic idle;
    for (int i = 0; i < 3000 && STATUS[0] !== 1'b0; i++) begin
      @(posedge MCLK);
    end
    @(posedge MCLK);
    #1;
  endtask
  initial begin
    #500_000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge MCLK);
    #1;
    NRST = 1'b1;
    one(`SFS_OP_WREN);
    chk(STATUS, 8'h00);
    repeat (300) @(posedge MCLK);
    go(`SFS_OP_WRSR, 32'hbc00_0000, 1);
    host.desel();
    chk(STATUS, 8'h00);
    one(`SFS_OP_WREN);
    rdsr(8'h02);
    one(`SFS_OP_WRDI);
    chk(STATUS, 8'h00);
    one(`SFS_OP_PD);
    one(`SFS_OP_WREN);
    chk(STATUS, 8'h00);
    one(`SFS_OP_RPD);
    one(`SFS_OP_WREN);
    chk(STATUS, 8'h02);
    go(`SFS_OP_WRSR, 32'hff00_0000, 1);
    host.desel();
    chk(STATUS, 8'hbd);
    chk({PFB, PRANGE}, 4'hf);
    one(`SFS_OP_WREN);
    host.hp = 1'b1;
    rdsr(8'hbd);
    host.hp = 1'b0;
    idle();
    chk(STATUS, 8'hbc);
    WP_N = 1'b0;
    one(`SFS_OP_WREN);
    go(`SFS_OP_WRSR, 0, 1);
    host.desel();
    chk(STATUS[7:2], 6'h2f);
    WP_N = 1'b1;
    one(`SFS_OP_WREN);
    go(`SFS_OP_WRSR, 0, 1);
    host.desel();
    idle();
    chk(STATUS, 8'h00);
    foreach (ops[i]) begin
      one(`SFS_OP_WREN);
      go(ops[i], 32'h0100_0000, ops[i] == `SFS_OP_CE ? 0 : 3);
      host.desel();
      chk(STATUS, 8'h01);
      idle();
      chk(STATUS, 8'h00);
    end
    host.m3 = 1'b1;
    go(`SFS_OP_READ, 32'h1234_5600, 3);
    #800;
    chk({RD_REQ, RD_READY, ADDR}, {2'b10, 24'h123456});
    host.xb(0, 1, 0, r);
    chk(r, 8'ha5);
    host.xb(0, 1, 0, r);
    chk(r, 8'h3c);
    host.desel();
    chk(SO_OE, 1'b0);
    host.m3 = 1'b0;
    go(`SFS_OP_DREAD, 32'h0001_0000, 4);
    chk(ADDR, 24'h000100);
    host.xb(0, 1, 1, r);
    chk(r, 8'ha5);
    host.xb(0, 1, 1, r);
    chk(r, 8'h3c);
    host.desel();
    one(`SFS_OP_WREN);
    NRST = 1'b0;
    // Select held low through reset must not count as the select edge
    host.cs_n = 1'b0;
    repeat (8) @(posedge MCLK);
    #1;
    chk({STATUS, SO_OE}, 9'h000);
    NRST = 1'b1;
    host.xb(`SFS_OP_READ, 0, 0, r);
    repeat (3) host.xb(8'h00, 0, 0, r);
    chk(RD_REQ, 1'b0);
    host.desel();
    finish_test();
  end
endmodule
